// >>> supply_line_manchester_port_map.vh
// Constants for the supply-line Manchester programming port
`ifndef SUPPLY_LINE_MANCHESTER_PORT_MAP_VH
`define SUPPLY_LINE_MANCHESTER_PORT_MAP_VH

// ==========================================================
// Register bus byte offsets
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_LAST_CMD     4'h8

// ==========================================================
// Control field positions and reset value
`define CTRL_DISABLE_BIT 0
`define CTRL_OTHER_BIT   1
`define CTRL_RESET       2'h0

// ==========================================================
// Frame layout
`define SPECIAL_ADDR     6'h3f
`define ACCESS_DATA      16'h62d2
`define LEN_READ         5'h0e
`define LEN_WRITE        5'h1e
`define CRC_BITS         5'h03
`define RESP_BITS        5'h18

// ==========================================================
// Checksum generator, x^3 terms below the top bit, and preset
`define CRC_POLY         3'h3
`define CRC_PRESET       3'h7

// ==========================================================
// Bit period limits in clock cycles (250 MHz)
`define MIN_PERIOD       16'h0010

`endif

// >>> supply_line_manchester_port.v
// Supply-line Manchester programming port, device side
`timescale 1ns/10ps
`include "supply_line_manchester_port_map.vh"
`default_nettype none

module supply_line_manchester_port #(
  parameter CNT_W = 16
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        vcc_level,
  input  wire        angle_pwm_in,
  input  wire        die_strap_low,
  input  wire        die_strap_high,
  output reg         pwm_out,
  output reg         pwm_oe,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  // ==========================================================
  // Receiver states
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SYNA = 2'd1;
  localparam [1:0] S_SYNB = 2'd2;
  localparam [1:0] S_BITS = 2'd3;
  // S_IDLE waits for the first rise, the mid edge of sync cell one.
  // S_SYNA waits for the falling boundary between the two sync cells.
  // S_SYNB times rise to rise, which is exactly one bit period.
  // S_BITS takes one mid-cell edge per period until the frame is full.

  // ==========================================================
  // Receiver, command and transmitter state

  reg [1:0]       rx_st_q;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] per_q;
  reg [4:0]       nbit_q;
  reg [28:0]      sr_q;
  reg [2:0]       crc_q;
  reg             rw_q;
  reg             line_q;
  reg [1:0]       ctrl_q;
  reg             prog_q;
  reg [1:0]       die_q;
  reg [2:0]       err_q;
  reg [2:0]       snap_q;
  reg             cmd_v_q;
  reg             cmd_rw_q;
  reg             cmd_ok_q;
  reg [3:0]       cmd_tgt_q;
  reg [5:0]       cmd_addr_q;
  reg [15:0]      cmd_data_q;
  reg             tx_busy_q;
  reg [CNT_W-1:0] tx_hp_q;
  reg [CNT_W-1:0] tx_cnt_q;
  reg             tx_half_q;
  reg [4:0]       tx_nbit_q;
  reg [23:0]      tx_sr_q;
  // Byte store reached by commands; even writes fill a byte pair.
  // Kept small on purpose: the real target map sits outside this block.
  reg [7:0]       mem [0:63];
  reg             abort_set;

  // Timing windows: a mid edge counts from 3/4 of a period on, and
  // silence beyond 5/4 of a period means the sender lost its edges.
  // Boundary edges fall at half a period and never look like bits.

  // ==========================================================
  // Receiver helpers
  wire            rise   = vcc_level & ~line_q;
  wire            edge_w = vcc_level ^ line_q;
  wire            bitv   = ~vcc_level;
  wire [CNT_W-1:0] early = per_q - (per_q >> 2);
  wire [CNT_W-1:0] late  = per_q + (per_q >> 2);
  wire            rw_now = (nbit_q == 5'd0) ? bitv : rw_q;
  wire [4:0]      flen   = rw_now ? `LEN_READ : `LEN_WRITE;
  wire [29:0]     fr     = {sr_q, bitv};
  wire            fb     = bitv ^ crc_q[2];
  wire            dis    = ctrl_q[`CTRL_DISABLE_BIT];
  wire            mid    = edge_w && (cnt_q >= early);

  // ==========================================================
  // Line edge history and strap sampling
  // Straps are taken as static levels; a strap change between frames
  // only shifts the die number used for the next command.
  always @(posedge sys_clk) begin
    if (reset) begin
      line_q <= 1'b0;
      die_q  <= 2'b00;
    end else begin
      line_q <= vcc_level;
      die_q  <= {die_strap_high, die_strap_low};
    end
  end

  // ==========================================================
  // Manchester receiver: sync timing, bit sampling, checksum
  // The period is re-measured on every frame so each command may use
  // its own rate. The checksum runs over every bit after the sync
  // cells and before the three check bits, most significant first.
  // A frame faster than the minimum period is dropped quietly, since
  // its cells could not be told apart reliably.
  always @(posedge sys_clk) begin
    if (reset) begin
      rx_st_q    <= S_IDLE;
      cnt_q      <= {CNT_W{1'b0}};
      per_q      <= {CNT_W{1'b1}};
      nbit_q     <= 5'd0;
      sr_q       <= 29'd0;
      crc_q      <= `CRC_PRESET;
      rw_q       <= 1'b0;
      cmd_v_q    <= 1'b0;
      cmd_rw_q   <= 1'b0;
      cmd_ok_q   <= 1'b0;
      cmd_tgt_q  <= 4'h0;
      cmd_addr_q <= 6'h00;
      cmd_data_q <= 16'h0000;
      abort_set  <= 1'b0;
    end else begin
      cmd_v_q   <= 1'b0;
      abort_set <= 1'b0;
      if (dis) begin
        rx_st_q <= S_IDLE;
      end else begin
        case (rx_st_q)
          S_IDLE: begin
            cnt_q <= {CNT_W{1'b0}};
            if (rise)
              rx_st_q <= S_SYNA;
          end
          // First sync cell ends with a falling boundary edge
          S_SYNA: begin
            cnt_q <= cnt_q + 1'b1;
            if (edge_w)
              rx_st_q <= S_SYNB;
            if (&cnt_q)
              rx_st_q <= S_IDLE;
          end
          // Rise to rise across the sync cells is one period
          S_SYNB: begin
            cnt_q <= cnt_q + 1'b1;
            if (rise) begin
              per_q  <= cnt_q + 1'b1;
              cnt_q  <= {CNT_W{1'b0}};
              nbit_q <= 5'd0;
              crc_q  <= `CRC_PRESET;
              if (cnt_q >= `MIN_PERIOD)
                rx_st_q <= S_BITS;
              else
                rx_st_q <= S_IDLE;
            end else if (&cnt_q) begin
              rx_st_q <= S_IDLE;
            end
          end
          // Boundary edges arrive near half a period and are skipped
          S_BITS: begin
            cnt_q <= cnt_q + 1'b1;
            if (mid) begin
              cnt_q  <= {CNT_W{1'b0}};
              nbit_q <= nbit_q + 1'b1;
              sr_q   <= fr[28:0];
              if (nbit_q == 5'd0)
                rw_q <= bitv;
              if (nbit_q + 5'd1 <= flen - `CRC_BITS)
                crc_q <= {crc_q[1:0], 1'b0} ^ (fb ? `CRC_POLY : 3'h0);
              if (nbit_q + 5'd1 == flen) begin
                rx_st_q  <= S_IDLE;
                cmd_v_q  <= 1'b1;
                cmd_rw_q <= rw_now;
                cmd_ok_q <= (crc_q == fr[2:0]);
                if (rw_now) begin
                  cmd_tgt_q  <= fr[12:9];
                  cmd_addr_q <= fr[8:3];
                end else begin
                  cmd_tgt_q  <= fr[28:25];
                  cmd_addr_q <= fr[24:19];
                  cmd_data_q <= fr[18:3];
                end
              end
            end else if (cnt_q > late) begin
              rx_st_q   <= S_IDLE;
              abort_set <= 1'b1;
            end
          end
          default: rx_st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Command decode
  // Commands act one cycle after their last bit. Access and exit codes
  // skip target matching; everything else needs programming mode,
  // a good checksum and a target bit of this die or a broadcast.
  // A read that finds the transmitter busy is dropped and only flagged.
  wire bcast   = (cmd_tgt_q == 4'h0);
  wire hit     = bcast | cmd_tgt_q[die_q];
  wire special = ~cmd_rw_q & (cmd_addr_q == `SPECIAL_ADDR);
  wire good    = cmd_v_q & cmd_ok_q;
  wire act     = good & prog_q & hit & ~special;
  wire start   = act & cmd_rw_q & ~tx_busy_q;
  wire bc_flag = bcast | ctrl_q[`CTRL_OTHER_BIT];
  wire [1:0] id_rep = bc_flag ? 2'b00 : die_q;
  // Odd addresses read one byte with the upper byte forced to zero
  wire [5:0] ra   = cmd_addr_q;
  wire [15:0] rdat = ra[0] ? {8'h00, mem[ra]}
                           : {mem[ra], mem[ra | 6'h01]};
  // Last half of the last bit: the response is over on this edge
  wire tx_end = tx_busy_q & tx_half_q & (tx_cnt_q == tx_hp_q)
              & (tx_nbit_q == `RESP_BITS - 5'd1);
  // Set wins over the clear that follows a reported response
  wire [2:0] err_set = {abort_set,
                        cmd_v_q & tx_busy_q,
                        cmd_v_q & ~cmd_ok_q};

  // ==========================================================
  // Mode, error flags and target register store
  // Flags reported in a response are snapshotted at its start, so a
  // flag raised while the response is on the line survives the clear
  // and goes out in the next response instead of being lost.
  // The disable bit wins over any code that completes in the same cycle.
  always @(posedge sys_clk) begin : exec_p
    integer i;
    if (reset) begin
      prog_q <= 1'b0;
      err_q  <= 3'b000;
      snap_q <= 3'b000;
      for (i = 0; i < 64; i = i + 1)
        mem[i] <= 8'h00;
    end else begin
      err_q <= (err_q & ~(tx_end ? snap_q : 3'b000)) | err_set;
      if (start)
        snap_q <= err_q;
      // Mode changes only on the disable bit or on a frame that checked out
      if (dis) begin
        prog_q <= 1'b0;
      end else if (good & special) begin
        prog_q <= (cmd_data_q == `ACCESS_DATA);
      end
      // Writes land even while a response is going out
      if (act & ~cmd_rw_q) begin
        if (ra[0]) begin
          mem[ra] <= cmd_data_q[7:0];
        end else begin
          mem[ra]         <= cmd_data_q[15:8];
          mem[ra | 6'h01] <= cmd_data_q[7:0];
        end
      end
    end
  end

  // ==========================================================
  // Response transmitter, half cells of the measured period
  // Each half cell lasts half the measured period rounded down, so an
  // odd period answers one cycle per bit faster; the controller has
  // to tolerate that small skew. A one is high then low on the line.
  // Frame: two zero sync bits, die number, flags, then sixteen data bits.
  wire tx_lvl = tx_sr_q[23] ^ tx_half_q;

  always @(posedge sys_clk) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_hp_q   <= {CNT_W{1'b0}};
      tx_cnt_q  <= {CNT_W{1'b0}};
      tx_half_q <= 1'b0;
      tx_nbit_q <= 5'd0;
      tx_sr_q   <= 24'h000000;
    end else if (start) begin
      // Load status and data in send order, sync bits first
      tx_busy_q <= 1'b1;
      tx_hp_q   <= (per_q >> 1) - 1'b1;
      tx_cnt_q  <= {CNT_W{1'b0}};
      tx_half_q <= 1'b0;
      tx_nbit_q <= 5'd0;
      tx_sr_q   <= {2'b00, id_rep, bc_flag, err_q, rdat};
    end else if (tx_busy_q) begin
      // Shift at the end of each second half cell
      tx_cnt_q <= tx_cnt_q + 1'b1;
      if (tx_cnt_q == tx_hp_q) begin
        tx_cnt_q  <= {CNT_W{1'b0}};
        tx_half_q <= ~tx_half_q;
        if (tx_half_q) begin
          tx_sr_q   <= {tx_sr_q[22:0], 1'b0};
          tx_nbit_q <= tx_nbit_q + 1'b1;
          if (tx_end)
            tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Open-drain output: angle data unless in programming mode
  // The pin is only ever pulled low; the pull-up makes the high level.
  // Entering programming mode cuts any angle pulse short at once.
  always @(posedge sys_clk) begin
    if (reset) begin
      pwm_out <= 1'b0;
      pwm_oe  <= 1'b0;
    end else begin
      pwm_out <= 1'b0;
      if (prog_q)
        pwm_oe <= tx_busy_q & ~tx_lvl;
      else
        pwm_oe <= ~angle_pwm_in;
    end
  end

  // ==========================================================
  // Avalon slave: one wait state, then a one-cycle answer
  // Requests are taken while waitrequest is high; waitrequest drops
  // for exactly one cycle with the read data already in place.
  // Only the control word is writable; unmapped reads return zero.
  wire req = avs_read | avs_write;
  // Status: bit0 mode, bit1 die zero, bit2 responding, bits5:3 flags.
  // Last command: address, direction, target and data of the last frame.

  always @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl_q          <= `CTRL_RESET;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest) begin
        case (avs_address)
          `REG_CTRL:     avs_readdata <= {30'h0, ctrl_q};
          `REG_STATUS:   avs_readdata <= {26'h0, err_q, tx_busy_q,
                                          die_q == 2'b00, prog_q};
          `REG_LAST_CMD: avs_readdata <= {cmd_data_q, 4'h0, cmd_tgt_q,
                                          1'b0, cmd_rw_q, cmd_addr_q};
          default:       avs_readdata <= 32'h0000_0000;
        endcase
      end
      // Write lands on the edge where the master sees wait low
      if (avs_write & ~avs_waitrequest & (avs_address == `REG_CTRL))
        ctrl_q <= avs_writedata[1:0];
    end
  end

endmodule // supply_line_manchester_port

`default_nettype wire

// >>> supply_line_controller_model.sv
// Programming controller that modulates the supply line
`timescale 1ns/10ps
`default_nettype none
`include "supply_line_manchester_port_map.vh"
module supply_line_controller_model (
  input  wire  sys_clk,
  output logic vcc_level
);
  initial vcc_level = 1'h0;
  // ==========================================================
  // Check bits, preset and polynomial from the shared map
  function automatic logic [2:0] crc(input logic [31:0] b, input int n);
    logic [2:0] c;
    logic       f;
    c = `CRC_PRESET;
    for (int i = n - 1; i >= 0; i--) begin
      f = b[i] ^ c[2];
      c = {c[1:0], 1'h0} ^ (f ? `CRC_POLY : 3'h0);
    end
    return c;
  endfunction
  // One half cell, levels change just after a rising edge
  task automatic half(input logic lvl, input int t);
    vcc_level <= lvl;
    repeat (t / 2) @(posedge sys_clk);
  endtask
  // Mode 0 good, 1 bad check bits, 2 stop after sync; t chosen per call
  task automatic send(input logic [31:0] b, input int n, input int t,
                      input int m);
    logic [2:0] c;
    c = crc(b, n) ^ ((m == 1) ? 3'h7 : 3'h0);
    for (int i = 0; i < 2; i++) begin
      half(1'h0, t);
      half(1'h1, t);
    end
    if (m != 2) begin
      for (int i = n - 1; i >= 0; i--) begin
        half(b[i], t);
        half(!b[i], t);
      end
      for (int i = 2; i >= 0; i--) begin
        half(c[i], t);
        half(!c[i], t);
      end
    end
    // Line idles low between frames, the abort case also waits it out
    vcc_level <= 1'h0;
    repeat ((m == 2) ? 2 * t : 1) @(posedge sys_clk);
  endtask
endmodule // supply_line_controller_model
`default_nettype wire

// >>> supply_line_manchester_port_monitor.sv
// Bus and pin checks for the supply-line programming port
`timescale 1ns/10ps
`default_nettype none
`include "supply_line_manchester_port_map.vh"
module supply_line_manchester_port_monitor (
  input wire        sys_clk,
  input wire        reset,
  input wire        pwm_out,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest
);
  logic [1:0] ctrl_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  // Shadow of the control bits, updated on the edge the write lands
  always @(posedge sys_clk) begin
    if (reset) ctrl_q <= 2'h0;
    else if (avs_write && !avs_waitrequest && avs_address == `REG_CTRL)
      ctrl_q <= avs_writedata[1:0];
  end
  // ==========================================================
  // Assertions
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer late or too long");
  a_no_spurious: assert property ($fell(avs_waitrequest) |->
    $past(avs_read || avs_write)) else $error("answer without request");
  a_rdata_hold: assert property (!(avs_read || avs_write) |=>
    $stable(avs_readdata)) else $error("read data moved while idle");
  a_ctrl_back: assert property (avs_read && avs_waitrequest &&
    avs_address == `REG_CTRL |=> avs_readdata == {30'h0, ctrl_q})
    else $error("control readback wrong");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
    avs_address != `REG_CTRL && avs_address != `REG_STATUS &&
    avs_address != `REG_LAST_CMD |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_off_disabled: assert property (avs_read && avs_waitrequest &&
    avs_address == `REG_STATUS && ctrl_q[0] |=> !avs_readdata[0])
    else $error("programming mode while disabled");
  a_stat_spare: assert property (avs_read && avs_waitrequest &&
    avs_address == `REG_STATUS |=> avs_readdata[31:6] == 26'h0)
    else $error("status spare bits set");
  a_open_drain: assert property (pwm_out == 1'h0)
    else $error("open-drain value not low");
endmodule // supply_line_manchester_port_monitor
bind supply_line_manchester_port supply_line_manchester_port_monitor mon (
  .sys_clk(sys_clk), .reset(reset), .pwm_out(pwm_out),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the supply-line programming port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        sys_clk, reset, angle_pwm_in, die_strap_low, die_strap_high;
  logic        avs_read, avs_write, avs_waitrequest, pwm_out, pwm_oe;
  logic [3:0]  avs_address, own;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  mem [64];
  logic [5:0]  a;
  logic [15:0] d;
  logic [1:0]  id;
  wire         vcc_level;
  int          n_errors, n_compared, cyc, k, t;
  supply_line_manchester_port uut (.sys_clk(sys_clk), .reset(reset),
    .vcc_level(vcc_level), .angle_pwm_in(angle_pwm_in),
    .die_strap_low(die_strap_low), .die_strap_high(die_strap_high),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  supply_line_controller_model ctl (.sys_clk(sys_clk),
    .vcc_level(vcc_level));
  always #2 sys_clk = !sys_clk;
  // Hang guard sized well above the planned traffic
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin n_errors++; end_sim(); end
  end
  // ==========================================================
  // Expectations and helpers
  function automatic int pick(); return 2 * $urandom_range(12, 20); endfunction
  function automatic logic [15:0] ed(input logic [5:0] x);
    return x[0] ? {8'h00, mem[x]} : {mem[x], mem[x + 6'h01]};
  endfunction
  function automatic logic [23:0] resp(input logic bc, input logic [2:0] f);
    return {2'h0, bc ? 2'h0 : id, bc, f, ed(a)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_read <= !w; avs_write <= w; avs_address <= ad; avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'h0) @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'h0; avs_write <= 1'h0;
  endtask
  task automatic rb(input logic [3:0] ad, input logic [31:0] m, e);
    bus(1'h0, ad, 32'h0000_0000);
    chk("readdata", e, q & m);
  endtask
  task automatic wc(input logic [3:0] tg, input logic [5:0] ad,
                    input logic [15:0] dd, input int m);
    ctl.send({5'h00, 1'h0, tg, ad, dd}, 27, t, m);
  endtask
  // Read command, then the reply sampled a quarter cell into each bit
  task automatic rd(input logic [3:0] tg, input int tr, input logic want,
                    input logic [23:0] ex);
    logic [23:0] r;
    int w;
    w = 0; r = 24'h00_0000;
    // Reply starts inside the last half cell, so watch while sending
    fork
      ctl.send({21'h0, 1'h1, tg, a}, 11, tr, 0);
    join_none
    while (pwm_oe !== 1'h1 && w < 24 * tr) begin @(posedge sys_clk); w++; end
    chk("reply_seen", {31'h0, want}, {31'h0, pwm_oe === 1'h1});
    if (pwm_oe === 1'h1) begin
      repeat (tr / 4) @(posedge sys_clk);
      for (int i = 23; i >= 0; i--) begin
        r[i] = !pwm_oe;
        repeat (tr) @(posedge sys_clk);
      end
      chk("reply", {8'h00, ex}, {8'h00, r});
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    sys_clk = 0; reset = 1; angle_pwm_in = 1; die_strap_low = 0;
    die_strap_high = 0; avs_read = 0; avs_write = 0; avs_address = 4'h0;
    avs_writedata = 32'h0000_0000; n_errors = 0; n_compared = 0; cyc = 0;
    id = 2'h0; a = 6'h02;
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    void'($urandom(32'hf049));
    repeat (10) @(posedge sys_clk);
    reset <= 1'h0;
    rb(4'h0, 32'hffff_ffff, 32'h0000_0000);
    rb(4'h4, 32'hffff_fffd, 32'h0000_0000);
    rb(4'hc, 32'hffff_ffff, 32'h0000_0000);
    rd(4'hf, pick(), 1'h0, 24'h00_0000);
    t = pick();
    bus(1'h1, 4'h0, 32'h0000_0001);
    wc(4'h0, 6'h3f, 16'h62d2, 0);
    rb(4'h4, 32'h0000_0001, 32'h0000_0000);
    bus(1'h1, 4'h0, 32'h0000_0000);
    angle_pwm_in <= 1'h0;
    repeat (4) @(posedge sys_clk);
    chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
    wc(4'h2, 6'h3f, 16'h62d2, 0);
    rb(4'h4, 32'h0000_0001, 32'h0000_0001);
    chk("pwm_oe", 32'h0, {31'h0, pwm_oe});
    for (k = 0; k < 4; k++) begin
      id = k[1:0]; own = 4'h1 << id; t = pick();
      {die_strap_high, die_strap_low} <= id;
      a = 6'($urandom_range(0, 30) * 2); d = 16'($urandom);
      wc(own | 4'($urandom), a, d, 0);
      {mem[a], mem[a + 6'h01]} = d;
      rd(own, t, 1'h1, resp(1'h0, 3'h0));
      a = a + 6'h01;
      rd(own, pick(), 1'h1, resp(1'h0, 3'h0));
      a = a - 6'h01;
      wc(4'hf ^ own, a, ~d, 0);
      rd(own, t, 1'h1, resp(1'h0, 3'h0));
    end
    rd(4'h0, t, 1'h1, resp(1'h1, 3'h0));
    bus(1'h1, 4'h0, 32'h0000_0002);
    rd(own, t, 1'h1, resp(1'h1, 3'h0));
    bus(1'h1, 4'h0, 32'h0000_0000);
    wc(4'h0, a, ~d, 1);
    rd(own, t, 1'h1, resp(1'h0, 3'h1));
    rd(own, t, 1'h1, resp(1'h0, 3'h0));
    ctl.send(32'h0000_0000, 0, t, 2);
    rd(own, t, 1'h1, resp(1'h0, 3'h4));
    fork
      rd(own, t, 1'h1, resp(1'h0, 3'h0));
      begin
        repeat (19 * t) @(posedge sys_clk);
        ctl.send({21'h0, 1'h1, own, a}, 11, t, 0);
      end
    join
    rd(own, t, 1'h1, resp(1'h0, 3'h2));
    wc(4'h1, 6'h3f, 16'($urandom_range(0, 16'h62d1)), 0);
    rb(4'h4, 32'h0000_0001, 32'h0000_0000);
    repeat (4) @(posedge sys_clk);
    chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
